// File: include/ddr_latency_map.vh
`ifndef DDR_LATENCY_MAP_VH
`define DDR_LATENCY_MAP_VH

// latency code field inside the configuration byte
`define LC_HIGH_BIT 7
`define LC_LOW_BIT 6

// latency code values
`define CODE_00 2'h0
`define CODE_01 2'h1
`define CODE_10 2'h2
`define CODE_11 2'h3

// ddr read types
`define RD_FAST 2'h0
`define RD_DUAL 2'h1
`define RD_QUAD 2'h2

// mode cycles, the same for every latency code
`define MODE_FAST 8'h04
`define MODE_DUAL 8'h02
`define MODE_QUAD 8'h01

// latency cycles per code and read type
`define LAT11_FAST 8'h01
`define LAT11_DUAL 8'h02
`define LAT11_QUAD 8'h03
`define LAT00_FAST 8'h02
`define LAT00_DUAL 8'h04
`define LAT00_QUAD 8'h06
`define LAT01_FAST 8'h04
`define LAT01_DUAL 8'h05
`define LAT01_QUAD 8'h07
`define LAT10_FAST 8'h05
`define LAT10_DUAL 8'h06
`define LAT10_QUAD 8'h08

// serial clock limit per code, in MHz
`define FREQ_LIMIT_11 8'h32
`define FREQ_LIMIT_66 8'h42

// latency table parameter header
`define LAT_PARAM_ID 8'h9A
`define LAT_PARAM_LEN 8'h2A
`define LAT_ROWS 8'h05
`define LAT_ROW_LEN 8'h08
`define LAT_PARAM_SIZE 6'h2C

// padding parameter
`define PAD_PARAM_ID 8'hF0
`define PAD_PARAM_LEN 8'h0F
`define PAD_BASE 8'h2C
`define RESERVED_BYTE 8'hFF

`endif

// File: rtl/latency_query_rom.v
`timescale 1ns/1ps
`include "ddr_latency_map.vh"

module latency_query_rom (
    input wire sys_clk, // serial clock
    input wire rst_b, // async reset, active low
    input wire [5:0] romAddr, // byte address in the latency parameter
    output reg [7:0] romData // registered byte
);

    reg [7:0] next_romData; // byte looked up this cycle

    // constant content of the ddr latency parameter
    always @* begin
        case (romAddr)
            6'h00: next_romData = `LAT_PARAM_ID;
            6'h01: next_romData = `LAT_PARAM_LEN;
            6'h02: next_romData = `LAT_ROWS;
            6'h03: next_romData = `LAT_ROW_LEN;
            6'h04: next_romData = 8'h46; // column header letter
            6'h05: next_romData = 8'h43; // column header letter
            6'h06: next_romData = 8'h0D; // fast ddr read, 3-byte address
            6'h07: next_romData = 8'h0E; // fast ddr read, 4-byte address
            6'h08: next_romData = 8'hBD; // dual i/o ddr read, 3-byte
            6'h09: next_romData = 8'hBE; // dual i/o ddr read, 4-byte
            6'h0A: next_romData = 8'hED; // quad i/o ddr read, 3-byte
            6'h0B: next_romData = 8'hEE; // quad i/o ddr read, 4-byte
            6'h0C: next_romData = `FREQ_LIMIT_11;
            6'h0D: next_romData = {6'h00, `CODE_11};
            6'h0E: next_romData = `MODE_FAST;
            6'h0F: next_romData = `LAT11_FAST;
            6'h10: next_romData = `MODE_DUAL;
            6'h11: next_romData = `LAT11_DUAL;
            6'h12: next_romData = `MODE_QUAD;
            6'h13: next_romData = `LAT11_QUAD;
            6'h14: next_romData = `FREQ_LIMIT_66;
            6'h15: next_romData = {6'h00, `CODE_00};
            6'h16: next_romData = `MODE_FAST;
            6'h17: next_romData = `LAT00_FAST;
            6'h18: next_romData = `MODE_DUAL;
            6'h19: next_romData = `LAT00_DUAL;
            6'h1A: next_romData = `MODE_QUAD;
            6'h1B: next_romData = `LAT00_QUAD;
            6'h1C: next_romData = `FREQ_LIMIT_66;
            6'h1D: next_romData = {6'h00, `CODE_01};
            6'h1E: next_romData = `MODE_FAST;
            6'h1F: next_romData = `LAT01_FAST;
            6'h20: next_romData = `MODE_DUAL;
            6'h21: next_romData = `LAT01_DUAL;
            6'h22: next_romData = `MODE_QUAD;
            6'h23: next_romData = `LAT01_QUAD;
            6'h24: next_romData = `FREQ_LIMIT_66;
            6'h25: next_romData = {6'h00, `CODE_10};
            6'h26: next_romData = `MODE_FAST;
            6'h27: next_romData = `LAT10_FAST;
            6'h28: next_romData = `MODE_DUAL;
            6'h29: next_romData = `LAT10_DUAL;
            6'h2A: next_romData = `MODE_QUAD;
            6'h2B: next_romData = `LAT10_QUAD;
            // past the end of the parameter
            default: next_romData = `RESERVED_BYTE;
        endcase
    end

    // read data leaves through a register
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            romData <= 8'h00;
        end else begin
            romData <= next_romData;
        end
    end

endmodule // latency_query_rom

// File: rtl/ddr_read_latency_table.v
`timescale 1ns/1ps
`include "ddr_latency_map.vh"

// Functional notes
// - code 11b: fast 4/1, dual 2/2, quad 1/3
// - code 00b: fast 4/2, dual 2/4, quad 1/6
// - code 01b: fast 4/4, dual 2/5, quad 1/7
// - code 10b: fast 4/5, dual 2/6, quad 1/8
// - padding only reserves or aligns query space
// - latency code is configuration bits 7:6
module ddr_read_latency_table #(
    parameter [7:0] PAD_LEN = `PAD_PARAM_LEN // length byte of the padding parameter
) (
    input wire sys_clk, // serial clock of the flash
    input wire rst_b, // async reset, active low
    input wire [7:0] configByte, // non-volatile configuration byte
    input wire [1:0] readType, // ddr read type of the command
    input wire readStart, // pulse: last address clock just passed
    input wire readEnd, // pulse: chip select released, read ends
    output wire modePhase, // level: mode cycles running
    output wire latencyPhase, // level: latency cycles running
    output wire dataDrive, // level: device drives read data
    output reg [7:0] modeCycles, // mode cycles of the current read
    output reg [7:0] latencyCycles, // latency cycles of the current read
    output reg [7:0] freqLimit, // serial clock limit in MHz of the code
    output reg typeError, // read type not a ddr read
    input wire queryReq, // pulse: query byte requested
    input wire [7:0] queryAddr, // byte address in the query area
    output reg [7:0] queryData, // query byte, two cycles after request
    output reg queryValid // pulse: one cycle ahead of queryData
);

    // sequencer states
    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_MODE = 2'b01;
    localparam [1:0] ST_LAT = 2'b10;
    localparam [1:0] ST_DATA = 2'b11;

    reg [1:0] state; // sequencer state
    reg [1:0] next_state; // next sequencer state
    reg [7:0] cycleCount; // remaining cycles of the phase
    reg [7:0] next_cycleCount; // next remaining count
    wire latency_code_high_bit; // upper latency code bit
    wire latency_code_low_bit; // lower latency code bit
    wire [1:0] latencyCode; // selected latency code
    wire [7:0] romData; // byte from the latency parameter
    reg [1:0] querySel; // where the pending query byte comes from
    reg [7:0] padByte; // byte of the padding area, registered

    assign latency_code_high_bit = configByte[`LC_HIGH_BIT];
    assign latency_code_low_bit = configByte[`LC_LOW_BIT];
    assign latencyCode = {latency_code_high_bit, latency_code_low_bit};

    // mode cycles depend on the read type only
    function [7:0] modeLookup;
        input [1:0] rtype;
        begin
            case (rtype)
                `RD_FAST: modeLookup = `MODE_FAST;
                `RD_DUAL: modeLookup = `MODE_DUAL;
                default: modeLookup = `MODE_QUAD;
            endcase
        end
    endfunction

    // latency cycles from code and read type
    function [7:0] latLookup;
        input [1:0] code;
        input [1:0] rtype;
        begin
            case (code)
                `CODE_11: latLookup = (rtype == `RD_FAST) ? `LAT11_FAST :
                    (rtype == `RD_DUAL) ? `LAT11_DUAL : `LAT11_QUAD;
                `CODE_00: latLookup = (rtype == `RD_FAST) ? `LAT00_FAST :
                    (rtype == `RD_DUAL) ? `LAT00_DUAL : `LAT00_QUAD;
                `CODE_01: latLookup = (rtype == `RD_FAST) ? `LAT01_FAST :
                    (rtype == `RD_DUAL) ? `LAT01_DUAL : `LAT01_QUAD;
                default: latLookup = (rtype == `RD_FAST) ? `LAT10_FAST :
                    (rtype == `RD_DUAL) ? `LAT10_DUAL : `LAT10_QUAD;
            endcase
        end
    endfunction

    // frequency ceiling that the host must respect for a code
    function [7:0] limitLookup;
        input [1:0] code;
        begin
            case (code)
                `CODE_11: limitLookup = `FREQ_LIMIT_11;
                default: limitLookup = `FREQ_LIMIT_66;
            endcase
        end
    endfunction

    // phase decode straight from the state register
    assign modePhase = (state == ST_MODE);
    assign latencyPhase = (state == ST_LAT);
    assign dataDrive = (state == ST_DATA);

    // next state and count of the read sequencer
    always @* begin
        next_state = state;
        next_cycleCount = cycleCount;
        if (readEnd) begin
            // release of chip select aborts any phase
            next_state = ST_IDLE;
            next_cycleCount = 8'h00;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (readStart) begin
                        next_state = ST_MODE;
                        next_cycleCount = modeLookup(readType) - 8'h01;
                    end
                end
                ST_MODE: begin
                    if (cycleCount == 8'h00) begin
                        next_state = ST_LAT;
                        next_cycleCount = latencyCycles - 8'h01;
                    end else begin
                        next_cycleCount = cycleCount - 8'h01;
                    end
                end
                ST_LAT: begin
                    if (cycleCount == 8'h00) begin
                        next_state = ST_DATA;
                    end else begin
                        next_cycleCount = cycleCount - 8'h01;
                    end
                end
                ST_DATA: begin
                    // data continues until chip select is released
                    next_state = ST_DATA;
                end
                default: begin
                    next_state = ST_IDLE;
                    next_cycleCount = 8'h00;
                end
            endcase
        end
    end

    // sequencer registers
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= ST_IDLE;
            cycleCount <= 8'h00;
        end else begin
            state <= next_state;
            cycleCount <= next_cycleCount;
        end
    end

    // settings of a read are latched at its start
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            modeCycles <= 8'h00;
            latencyCycles <= 8'h00;
            freqLimit <= 8'h00;
            typeError <= 1'b0;
        end else if (readStart && !readEnd && state == ST_IDLE) begin
            modeCycles <= modeLookup(readType);
            latencyCycles <= latLookup(latencyCode, readType);
            freqLimit <= limitLookup(latencyCode);
            // an unknown type is run as a quad read and flagged
            typeError <= (readType == 2'h3);
        end
    end

    // latency parameter bytes
    latency_query_rom latency_query_rom_inst (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .romAddr(queryAddr[5:0]),
        .romData(romData)
    );

    // padding area and source select, aligned with the rom register
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            querySel <= 2'b00;
            padByte <= 8'h00;
            queryValid <= 1'b0;
        end else begin
            // strobe leads the byte by one cycle, so a host takes data one cycle later
            queryValid <= queryReq;
            querySel <= (queryAddr < {2'b00, `LAT_PARAM_SIZE}) ? 2'b01 : 2'b10;
            if (queryAddr == `PAD_BASE) begin
                padByte <= `PAD_PARAM_ID;
            end else if (queryAddr == `PAD_BASE + 8'h01) begin
                padByte <= PAD_LEN;
            end else begin
                padByte <= `RESERVED_BYTE;
            end
        end
    end

    // query answer register
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            queryData <= 8'h00;
        end else if (querySel == 2'b01) begin
            queryData <= romData;
        end else begin
            queryData <= padByte;
        end
    end

endmodule // ddr_read_latency_table

// File: dv/ddr_read_latency_table_monitor.sv
`timescale 1ns/1ps
module ddr_read_latency_table_monitor #(
    parameter [7:0] PAD_LEN = 8'h0F // padding length
) (
    input wire sys_clk, // clock
    input wire rst_b, // reset
    input wire [7:0] configByte, // config
    input wire [1:0] readType, // type
    input wire readStart, // start
    input wire readEnd, // end
    input wire modePhase, // mode
    input wire latencyPhase, // latency
    input wire dataDrive, // data
    input wire [7:0] modeCycles, // mode count
    input wire [7:0] latencyCycles, // latency count
    input wire [7:0] freqLimit, // ceiling
    input wire typeError, // bad type
    input wire queryReq, // query
    input wire [7:0] queryAddr, // address
    input wire [7:0] queryData, // byte
    input wire queryValid // strobe
);
    reg [7:0] cntM; // mode cycles seen
    reg [7:0] cntL; // latency cycles seen
    wire idle = !modePhase && !latencyPhase && !dataDrive; // sequencer idle
    wire [1:0] code = configByte[7:6]; // latency code
    // count high cycles of each phase
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cntM <= 8'h00;
            cntL <= 8'h00;
        end else begin
            cntM <= modePhase ? cntM + 8'h01 : 8'h00;
            cntL <= latencyPhase ? cntL + 8'h01 : 8'h00;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    sequence s_take;
        idle && readStart && !readEnd;
    endsequence
    sequence s_qHeld(a);
        queryReq && queryAddr == a ##1 queryAddr == a;
    endsequence
    property p_start; s_take |=> modePhase && !latencyPhase; endproperty
    a_start: assert property (p_start) else $error("no mode phase");
    property p_modeLen; $fell(modePhase) && latencyPhase |-> cntM == modeCycles; endproperty
    a_modeLen: assert property (p_modeLen) else $error("mode length");
    property p_latLen; $fell(latencyPhase) && dataDrive |-> cntL == latencyCycles; endproperty
    a_latLen: assert property (p_latLen) else $error("latency length");
    property p_end; readEnd |=> idle; endproperty
    a_end: assert property (p_end) else $error("not idle after end");
    property p_lat11;
        s_take ##0 code == 2'h3 |=> latencyCycles ==
            ($past(readType) == 2'h0 ? 8'h01 : $past(readType) == 2'h1 ? 8'h02 : 8'h03);
    endproperty
    a_lat11: assert property (p_lat11) else $error("latency code 3");
    property p_freq; s_take |=> freqLimit == (($past(code) == 2'h3) ? 8'h32 : 8'h42); endproperty
    a_freq: assert property (p_freq) else $error("clock ceiling");
    property p_type; s_take |=> typeError == ($past(readType) == 2'h3); endproperty
    a_type: assert property (p_type) else $error("type flag");
    property p_qValid; queryReq |=> queryValid; endproperty
    a_qValid: assert property (p_qValid) else $error("query strobe");
    property p_qPad; s_qHeld(8'h2C) |=> queryData == 8'hF0; endproperty
    a_qPad: assert property (p_qPad) else $error("padding id");
    property p_qLen; s_qHeld(8'h2D) |=> queryData == PAD_LEN; endproperty
    a_qLen: assert property (p_qLen) else $error("padding length");
    property p_qRes;
        queryReq && queryAddr > 8'h2D && queryAddr <= 8'h2D + PAD_LEN ##1 $stable(queryAddr)
            |=> queryData == 8'hFF;
    endproperty
    a_qRes: assert property (p_qRes) else $error("reserved byte");
endmodule // ddr_read_latency_table_monitor

// File: dv/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
    input wire sys_clk, // serial clock
    input wire modePhase, // mode phase
    input wire latencyPhase, // latency phase
    input wire dataDrive, // data phase
    output reg [7:0] configByte, // config byte
    output reg [1:0] readType, // read type
    output reg readStart, // start pulse
    output reg readEnd // end pulse
);
    reg [7:0] mCnt; // mode cycles seen
    reg [7:0] lCnt; // latency cycles seen
    // idle levels at time zero
    initial begin
        configByte = 8'h00;
        readType = 2'h0;
        readStart = 1'b0;
        readEnd = 1'b0;
    end
    // clock under ceilings
    // one read; nonzero cut repeats start while busy then aborts
    task read(input [1:0] code, input [1:0] rtype, input [7:0] cut);
        integer n;
        begin
            @(negedge sys_clk);
            configByte = {code, 6'h15};
            readType = rtype;
            readStart = 1'b1;
            @(negedge sys_clk);
            readStart = (cut != 8'h00);
            configByte = ~configByte;
            readType = ~rtype;
            mCnt = 8'h00;
            lCnt = 8'h00;
            if (cut != 8'h00) begin
                @(negedge sys_clk);
                readStart = 1'b0;
                repeat (cut) @(negedge sys_clk);
            end else begin
                for (n = 0; n < 40 && !dataDrive; n = n + 1) begin
                    mCnt = mCnt + {7'h00, modePhase};
                    lCnt = lCnt + {7'h00, latencyPhase};
                    @(negedge sys_clk);
                end
                @(negedge sys_clk);
            end
            readEnd = 1'b1;
            @(negedge sys_clk);
            readEnd = 1'b0;
        end
    endtask
endmodule // spi_host_model

// File: dv/tb_ddr_read_latency_table.sv
`timescale 1ns/1ps
module tb_ddr_read_latency_table;
    // mode cycles quad, dual, fast
    localparam [23:0] MODE = {8'h01, 8'h02, 8'h04};
    // latency per code, quad down to fast, code 3 first
    localparam [95:0] LAT = {8'h03, 8'h02, 8'h01, 8'h08, 8'h06, 8'h05,
                             8'h07, 8'h05, 8'h04, 8'h06, 8'h04, 8'h02};
    reg sys_clk, rst_b, queryReq; // clock, reset, query strobe
    reg [7:0] queryAddr; // query address
    wire [7:0] configByte, modeCycles, latencyCycles, freqLimit, queryData; // bytes
    wire [1:0] readType; // read type
    wire readStart, readEnd, modePhase, latencyPhase, dataDrive, typeError, queryValid; // flags
    integer errors, compares, c, t, r, a; // counters and loop indices
    ddr_read_latency_table #(.PAD_LEN(8'h0F)) ddr_read_latency_table_inst (
        .sys_clk(sys_clk), .rst_b(rst_b), .configByte(configByte), .readType(readType),
        .readStart(readStart), .readEnd(readEnd), .modePhase(modePhase),
        .latencyPhase(latencyPhase), .dataDrive(dataDrive), .modeCycles(modeCycles),
        .latencyCycles(latencyCycles), .freqLimit(freqLimit), .typeError(typeError),
        .queryReq(queryReq), .queryAddr(queryAddr), .queryData(queryData),
        .queryValid(queryValid));
    spi_host_model spi_host_model_inst (
        .sys_clk(sys_clk), .modePhase(modePhase), .latencyPhase(latencyPhase),
        .dataDrive(dataDrive), .configByte(configByte), .readType(readType),
        .readStart(readStart), .readEnd(readEnd));
    // byte compare
    task cmp8(input [7:0] got, input [7:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // one query byte, address held two cycles
    task query(input [7:0] addr, input [7:0] exp);
        begin
            @(negedge sys_clk);
            queryReq = 1'b1;
            queryAddr = addr;
            @(negedge sys_clk);
            queryReq = 1'b0;
            cmp8({7'h00, queryValid}, 8'h01);
            @(negedge sys_clk);
            cmp8(queryData, exp);
        end
    endtask
    // abort in latency phase after an ignored second start
    task test_abort;
        begin
            spi_host_model_inst.read(2'h2, 2'h2, 8'h03);
            cmp8({5'h00, modePhase, latencyPhase, dataDrive}, 8'h00);
            cmp8(latencyCycles, 8'h08);
        end
    endtask
    // every code and read type, counted at the ports
    task test_table;
        begin
            for (c = 0; c < 4; c = c + 1) begin
                for (t = 0; t < 4; t = t + 1) begin
                    r = (t > 2) ? 2 : t;
                    spi_host_model_inst.read(c[1:0], t[1:0], 8'h00);
                    cmp8(spi_host_model_inst.mCnt, MODE[r*8 +: 8]);
                    cmp8(spi_host_model_inst.lCnt, LAT[(c*3+r)*8 +: 8]);
                    cmp8(modeCycles, MODE[r*8 +: 8]);
                    cmp8(latencyCycles, LAT[(c*3+r)*8 +: 8]);
                    cmp8(freqLimit, (c == 3) ? 8'h32 : 8'h42);
                    cmp8({7'h00, typeError}, (t == 3) ? 8'h01 : 8'h00);
                end
            end
        end
    endtask
    // padding header, reserved run, latency parameter bytes 2B and 0D
    task test_query;
        begin
            query(8'h2C, 8'hF0);
            query(8'h2D, 8'h0F);
            for (a = 8'h2E; a < 8'h3D; a = a + 1)
                query(a[7:0], 8'hFF);
            query(8'h2B, 8'h08);
            query(8'h0D, 8'h03);
        end
    endtask
    // counts and verdict
    task end_sim;
        begin
            $display("compares %0d errors %0d", compares, errors);
            if (errors == 0 && compares > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    // 25 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // reset then scenarios
    initial begin
        errors = 0;
        compares = 0;
        rst_b = 1'b0;
        queryReq = 1'b0;
        queryAddr = 8'h00;
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
        rst_b = 1'b1;
        test_abort;
        test_table;
        test_query;
        end_sim;
    end
    // watchdog, about ten times the expected run
    initial begin
        #100000;
        errors = errors + 1;
        end_sim;
    end
endmodule // tb_ddr_read_latency_table
bind ddr_read_latency_table ddr_read_latency_table_monitor #(.PAD_LEN(PAD_LEN)) mon_inst (
    .sys_clk(sys_clk), .rst_b(rst_b), .configByte(configByte), .readType(readType),
    .readStart(readStart), .readEnd(readEnd), .modePhase(modePhase),
    .latencyPhase(latencyPhase), .dataDrive(dataDrive), .modeCycles(modeCycles),
    .latencyCycles(latencyCycles), .freqLimit(freqLimit), .typeError(typeError),
    .queryReq(queryReq), .queryAddr(queryAddr), .queryData(queryData),
    .queryValid(queryValid));
